//--- hdl/pfc_consts.svh
/*
 * Register indices, field positions, reset values and event encodings of
 * the performance event counter block.
 * Assumes word-indexed APB decode: byte address is four times the index.
 */
`ifndef PFC_CONSTS_SVH
`define PFC_CONSTS_SVH

// ****************************************************************
// register indices (byte address = index * 4)
// ****************************************************************
`define PFC_IDX_FIX0_LO 10'h309
`define PFC_IDX_FIX1_LO 10'h30A
`define PFC_IDX_FIX2_LO 10'h30B
`define PFC_IDX_FIX0_HI 10'h389
`define PFC_IDX_FIX1_HI 10'h38A
`define PFC_IDX_FIX2_HI 10'h38B
`define PFC_IDX_FIX_CTRL 10'h38D
`define PFC_IDX_GP0_LO 10'h0C1
`define PFC_IDX_GP1_LO 10'h0C2
`define PFC_IDX_GP0_HI 10'h0D1
`define PFC_IDX_GP1_HI 10'h0D2
`define PFC_IDX_EVSEL0 10'h186
`define PFC_IDX_EVSEL1 10'h187
`define PFC_IDX_STATUS 10'h38E

// ****************************************************************
// fixed counter control fields
// ****************************************************************
`define PFC_CTL_EN0 0
`define PFC_CTL_EN1 4
`define PFC_CTL_ANY_THREAD 6
`define PFC_CTL_EN2 8
`define PFC_CTL_BUS_CLK_REF 12
`define PFC_CTL_MASK 32'h0000_1151
`define PFC_CTL_RESET 32'h0000_0000

// ****************************************************************
// event select fields
// ****************************************************************
`define PFC_SEL_CODE_LSB 0
`define PFC_SEL_UMASK_LSB 8
`define PFC_SEL_EN 22
`define PFC_SEL_MASK 32'h0040_FFFF
`define PFC_SEL_RESET 32'h0000_0000

// ****************************************************************
// architectural event encodings
// ****************************************************************
`define PFC_EV_CYCLES 8'h3C
`define PFC_UM_CORE 8'h00
`define PFC_UM_REF 8'h01
`define PFC_EV_INSTR 8'hC0
`define PFC_UM_INSTR 8'h00
`define PFC_EV_LLC 8'h2E
`define PFC_UM_LLC_REF 8'h4F
`define PFC_UM_LLC_MISS 8'h41
`define PFC_EV_BRANCH 8'hC4
`define PFC_UM_BRANCH 8'h00
`define PFC_EV_MISPRED 8'hC5
`define PFC_UM_MISPRED 8'h00

`endif

//--- hdl/pfc_pkg.sv
/*
 * Types of the performance event counter block.
 * Assumes pfc_consts.svh supplies the numbers.
 */
package pfc_pkg;

  // ****************************************************************
  // per-cycle indications from the core pipeline (core clock domain)
  // ****************************************************************
  typedef struct packed {
    logic instr_retired;
    logic branch_retired;
    logic branch_mispred;
    logic last_level_cache_reference_event;
    logic llc_miss;
    logic halt_instruction;
    logic monitor_wait_instruction;
    logic thermal_stop_clock;
    logic sibling_unhalted;
  } pfc_core_ev_t;

  typedef struct packed {
    logic [7:0] umask;
    logic [7:0] code;
  } pfc_evsel_t;

endpackage

//--- hdl/pfc_counter64.sv
/*
 * One 64-bit event counter with word-wise software load.
 * Assumes inc, wr_lo and wr_hi are synchronous to clk.
 */
`timescale 1ns/1ns

module pfc_counter64 (
  input wire logic clk,
  input wire logic resetn,
  input wire logic inc,
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [31:0] wdata,
  output logic [63:0] value
);

  logic [63:0] sum;
  logic [63:0] next_value;

  // a software load wins over a count in the same cycle for that half
  assign sum = value + {63'h0, inc};
  assign next_value = {wr_hi ? wdata : sum[63:32], wr_lo ? wdata : sum[31:0]};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      value <= 64'h0;
    end else begin
      value <= next_value;
    end
  end

endmodule

//--- hdl/pfc_top.sv
/*
 * Performance event counters: three fixed-function counters and two
 * general-purpose counters with event select, behind an APB slave.
 * Assumes core event indications are on clk; the time-stamp tick and the
 * bus-clock tick are toggling levels from other clocks, slower than clk/2.
 */
`timescale 1ns/1ns
`include "pfc_consts.svh"

// How it works
// - cycle events 3C/00 and 3C/01 selectable
// - 2E/4F counts last-level cache references
// - 2E/41 counts last-level cache misses
// - C4/00 counts retired branches
// - C5/00 counts retired mispredicted branches
// - fixed counters count only their own event
// - fixed counter 0 counts final-uop retirements
// - interrupts and traps never pause counter 0
// - fixed counter 1 counts unhalted core cycles
// - single-thread core counts whole core cycles
// - any-thread bit 6 counts any thread
// - counter 2 stops in halt or thermal stop
// - halt and monitor-wait mean halted
// - reference counter ticks at time-stamp rate
// - core-cycle counter follows actual core clock
// - legacy mode counts bus clocks instead
module pfc_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pfc_pkg::pfc_core_ev_t core_ev,
  input wire logic tsc_tick_toggle,
  input wire logic bus_clk_toggle
);

  // ****************************************************************
  // core indications, registered once (same clock, no synchroniser)
  // ****************************************************************
  pfc_pkg::pfc_core_ev_t ev_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ev_q <= '0;
    end else begin
      ev_q <= core_ev;
    end
  end

  // ****************************************************************
  // reference tick crossing: two flops, then an edge flop
  // ****************************************************************
  logic [2:0] tsc_sync;
  logic [2:0] bus_sync;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tsc_sync <= 3'h0;
      bus_sync <= 3'h0;
    end else begin
      tsc_sync <= {tsc_sync[1:0], tsc_tick_toggle};
      bus_sync <= {bus_sync[1:0], bus_clk_toggle};
    end
  end

  wire tsc_edge = tsc_sync[2] ^ tsc_sync[1];
  wire bus_edge = bus_sync[2] ^ bus_sync[1];

  // ****************************************************************
  // apb slave
  // ****************************************************************
  logic [31:0] fix_ctrl;
  logic [31:0] evsel0;
  logic [31:0] evsel1;
  logic [63:0] fix0;
  logic [63:0] fix1;
  logic [63:0] fix2;
  logic [63:0] gp0;
  logic [63:0] gp1;

  wire [9:0] idx = paddr[11:2];
  wire setup = psel && !penable;
  wire access_done = psel && penable && pready;
  wire wr_stb = access_done && pwrite && !pslverr;

  function automatic logic pfc_hit(input logic [9:0] i);
    pfc_hit = (i == `PFC_IDX_FIX0_LO) || (i == `PFC_IDX_FIX1_LO) ||
              (i == `PFC_IDX_FIX2_LO) || (i == `PFC_IDX_FIX0_HI) ||
              (i == `PFC_IDX_FIX1_HI) || (i == `PFC_IDX_FIX2_HI) ||
              (i == `PFC_IDX_FIX_CTRL) || (i == `PFC_IDX_GP0_LO) ||
              (i == `PFC_IDX_GP1_LO) || (i == `PFC_IDX_GP0_HI) ||
              (i == `PFC_IDX_GP1_HI) || (i == `PFC_IDX_EVSEL0) ||
              (i == `PFC_IDX_EVSEL1) || (i == `PFC_IDX_STATUS);
  endfunction

  wire hit = pfc_hit(idx) && (paddr[1:0] == 2'h0);
  wire wr_fix0_lo = wr_stb && (idx == `PFC_IDX_FIX0_LO);
  wire wr_fix1_lo = wr_stb && (idx == `PFC_IDX_FIX1_LO);
  wire wr_fix2_lo = wr_stb && (idx == `PFC_IDX_FIX2_LO);
  wire wr_fix0_hi = wr_stb && (idx == `PFC_IDX_FIX0_HI);
  wire wr_fix1_hi = wr_stb && (idx == `PFC_IDX_FIX1_HI);
  wire wr_fix2_hi = wr_stb && (idx == `PFC_IDX_FIX2_HI);
  wire wr_gp0_lo = wr_stb && (idx == `PFC_IDX_GP0_LO);
  wire wr_gp1_lo = wr_stb && (idx == `PFC_IDX_GP1_LO);
  wire wr_gp0_hi = wr_stb && (idx == `PFC_IDX_GP0_HI);
  wire wr_gp1_hi = wr_stb && (idx == `PFC_IDX_GP1_HI);
  wire wr_ctrl = wr_stb && (idx == `PFC_IDX_FIX_CTRL);
  wire wr_sel0 = wr_stb && (idx == `PFC_IDX_EVSEL0);
  wire wr_sel1 = wr_stb && (idx == `PFC_IDX_EVSEL1);

  // core halted when running halt or monitor-wait
  wire halted = ev_q.halt_instruction || ev_q.monitor_wait_instruction;
  wire [31:0] status_word = {28'h0, ev_q.sibling_unhalted, ev_q.thermal_stop_clock,
                             halted, 1'b0};

  function automatic logic [31:0] pfc_read(input logic [9:0] i);
    unique case (i)
      `PFC_IDX_FIX0_LO: pfc_read = fix0[31:0];
      `PFC_IDX_FIX1_LO: pfc_read = fix1[31:0];
      `PFC_IDX_FIX2_LO: pfc_read = fix2[31:0];
      `PFC_IDX_FIX0_HI: pfc_read = fix0[63:32];
      `PFC_IDX_FIX1_HI: pfc_read = fix1[63:32];
      `PFC_IDX_FIX2_HI: pfc_read = fix2[63:32];
      `PFC_IDX_FIX_CTRL: pfc_read = fix_ctrl;
      `PFC_IDX_GP0_LO: pfc_read = gp0[31:0];
      `PFC_IDX_GP1_LO: pfc_read = gp1[31:0];
      `PFC_IDX_GP0_HI: pfc_read = gp0[63:32];
      `PFC_IDX_GP1_HI: pfc_read = gp1[63:32];
      `PFC_IDX_EVSEL0: pfc_read = evsel0;
      `PFC_IDX_EVSEL1: pfc_read = evsel1;
      `PFC_IDX_STATUS: pfc_read = status_word;
      default: pfc_read = 32'h0;
    endcase
  endfunction

  // reads are a snapshot taken in the setup cycle, never a side effect
  wire [31:0] rd_word = pfc_read(idx);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup && !hit;
      prdata <= (setup && !pwrite && hit) ? rd_word : 32'h0;
    end
  end

  // ****************************************************************
  // control and event select registers
  // ****************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fix_ctrl <= `PFC_CTL_RESET;
      evsel0 <= `PFC_SEL_RESET;
      evsel1 <= `PFC_SEL_RESET;
    end else begin
      if (wr_ctrl) begin
        fix_ctrl <= pwdata & `PFC_CTL_MASK;
      end
      if (wr_sel0) begin
        evsel0 <= pwdata & `PFC_SEL_MASK;
      end
      if (wr_sel1) begin
        evsel1 <= pwdata & `PFC_SEL_MASK;
      end
    end
  end

  wire en0 = fix_ctrl[`PFC_CTL_EN0];
  wire en1 = fix_ctrl[`PFC_CTL_EN1];
  wire en2 = fix_ctrl[`PFC_CTL_EN2];
  wire any_thread = fix_ctrl[`PFC_CTL_ANY_THREAD];
  wire bus_ref = fix_ctrl[`PFC_CTL_BUS_CLK_REF];

  // ****************************************************************
  // qualified events
  // ****************************************************************
  // every clk edge is a core cycle, so frequency changes show directly
  wire core_unhalted = !halted;
  // a lone thread has no sibling, so its own cycles are the core's
  wire core_any_unhalted = !halted || ev_q.sibling_unhalted;
  wire ref_tick = bus_ref ? bus_edge : tsc_edge;
  wire ref_unhalted = ref_tick && !halted && !ev_q.thermal_stop_clock;

  // no interrupt or trap term gates the retirement count
  wire inc_fix0 = en0 && ev_q.instr_retired;
  wire inc_fix1 = en1 && (any_thread ? core_any_unhalted : core_unhalted);
  wire inc_fix2 = en2 && ref_unhalted;

  function automatic logic pfc_gp_event(input logic [31:0] sel,
                                        input pfc_pkg::pfc_core_ev_t e,
                                        input logic cyc,
                                        input logic refc);
    pfc_pkg::pfc_evsel_t s;
    s = sel[15:0];
    pfc_gp_event = 1'b0;
    if (sel[`PFC_SEL_EN]) begin
      if (s.code == `PFC_EV_CYCLES && s.umask == `PFC_UM_CORE) begin
        pfc_gp_event = cyc;
      end else if (s.code == `PFC_EV_CYCLES && s.umask == `PFC_UM_REF) begin
        pfc_gp_event = refc;
      end else if (s.code == `PFC_EV_INSTR && s.umask == `PFC_UM_INSTR) begin
        pfc_gp_event = e.instr_retired;
      end else if (s.code == `PFC_EV_LLC && s.umask == `PFC_UM_LLC_REF) begin
        pfc_gp_event = e.last_level_cache_reference_event;
      end else if (s.code == `PFC_EV_LLC && s.umask == `PFC_UM_LLC_MISS) begin
        pfc_gp_event = e.llc_miss;
      end else if (s.code == `PFC_EV_BRANCH && s.umask == `PFC_UM_BRANCH) begin
        pfc_gp_event = e.branch_retired;
      end else if (s.code == `PFC_EV_MISPRED && s.umask == `PFC_UM_MISPRED) begin
        pfc_gp_event = e.branch_mispred;
      end
    end
  endfunction

  // unlisted encodings count nothing rather than something undefined
  wire inc_gp0 = pfc_gp_event(evsel0, ev_q, core_unhalted, ref_unhalted);
  wire inc_gp1 = pfc_gp_event(evsel1, ev_q, core_unhalted, ref_unhalted);

  // ****************************************************************
  // counters
  // ****************************************************************
  // fixed counters take no event select, so nothing can redirect them
  pfc_counter64 u_fix0 (.clk(clk), .resetn(resetn), .inc(inc_fix0), .wr_lo(wr_fix0_lo),
    .wr_hi(wr_fix0_hi), .wdata(pwdata), .value(fix0));
  pfc_counter64 u_fix1 (.clk(clk), .resetn(resetn), .inc(inc_fix1), .wr_lo(wr_fix1_lo),
    .wr_hi(wr_fix1_hi), .wdata(pwdata), .value(fix1));
  pfc_counter64 u_fix2 (.clk(clk), .resetn(resetn), .inc(inc_fix2), .wr_lo(wr_fix2_lo),
    .wr_hi(wr_fix2_hi), .wdata(pwdata), .value(fix2));
  pfc_counter64 u_gp0 (.clk(clk), .resetn(resetn), .inc(inc_gp0), .wr_lo(wr_gp0_lo),
    .wr_hi(wr_gp0_hi), .wdata(pwdata), .value(gp0));
  pfc_counter64 u_gp1 (.clk(clk), .resetn(resetn), .inc(inc_gp1), .wr_lo(wr_gp1_lo),
    .wr_hi(wr_gp1_hi), .wdata(pwdata), .value(gp1));

  // ****************************************************************
  // checks
  // ****************************************************************
  wire [7:0] sel0_code = evsel0[7:0];
  wire [7:0] sel0_umask = evsel0[15:8];
  wire sel0_on = evsel0[`PFC_SEL_EN];

  chk_gp_core_cycles: assert property (
    @(posedge clk) disable iff (!resetn)
    (sel0_on && sel0_code == 8'h3C && sel0_umask == 8'h00 && !halted && !wr_stb)
      |=> gp0 == $past(gp0) + 64'h1)
    else $error("gp counter missed an unhalted core cycle");

  chk_gp_llc_ref: assert property (
    @(posedge clk) disable iff (!resetn)
    (sel0_on && sel0_code == 8'h2E && sel0_umask == 8'h4F && !wr_stb)
      |=> gp0 == $past(gp0) + {63'h0, $past(ev_q.last_level_cache_reference_event)})
    else $error("gp counter does not track cache references");

  chk_gp_llc_miss: assert property (
    @(posedge clk) disable iff (!resetn)
    (sel0_on && sel0_code == 8'h2E && sel0_umask == 8'h41 && !wr_stb)
      |=> gp0 == $past(gp0) + {63'h0, $past(ev_q.llc_miss)})
    else $error("gp counter does not track cache misses");

  chk_gp_branch: assert property (
    @(posedge clk) disable iff (!resetn)
    (sel0_on && sel0_code == 8'hC4 && sel0_umask == 8'h00 && ev_q.branch_retired && !wr_stb)
      |=> gp0 != $past(gp0))
    else $error("retired branch not counted");

  chk_gp_mispred: assert property (
    @(posedge clk) disable iff (!resetn)
    (sel0_on && sel0_code == 8'hC5 && sel0_umask == 8'h00 && !ev_q.branch_mispred && !wr_stb)
      |=> $stable(gp0))
    else $error("mispredict counter moved without a mispredict");

  chk_fix0_only: assert property (
    @(posedge clk) disable iff (!resetn)
    (!ev_q.instr_retired && !wr_stb) |=> $stable(fix0))
    else $error("fixed counter 0 counted a foreign event");

  chk_fix0_retire: assert property (
    @(posedge clk) disable iff (!resetn)
    (en0 && ev_q.instr_retired && !wr_stb) |=> fix0 == $past(fix0) + 64'h1)
    else $error("retired instruction not counted");

  chk_fix1_unhalted: assert property (
    @(posedge clk) disable iff (!resetn)
    (en1 && !halted && !wr_stb) ##1 (en1 && !halted && !wr_stb)
      |=> fix1 == $past(fix1, 2) + 64'h2)
    else $error("core cycle counter lost an unhalted cycle");

  chk_fix1_any: assert property (
    @(posedge clk) disable iff (!resetn)
    (en1 && halted && !wr_stb) |=> (fix1 != $past(fix1)) == $past(any_thread && ev_q.sibling_unhalted))
    else $error("any-thread selection wrong on core cycle counter");

  chk_fix2_stop: assert property (
    @(posedge clk) disable iff (!resetn)
    ((halted || ev_q.thermal_stop_clock) && !wr_stb) |=> $stable(fix2))
    else $error("reference counter ran while halted or stopped");

  chk_halt_monitor_wait_instruction: assert property (
    @(posedge clk) disable iff (!resetn)
    (ev_q.monitor_wait_instruction && !any_thread && !wr_stb) |=> $stable(fix1))
    else $error("monitor-wait not treated as halted");

  chk_ref_rate: assert property (
    @(posedge clk) disable iff (!resetn)
    (!bus_ref && !tsc_edge && !wr_stb) |=> $stable(fix2))
    else $error("reference counter ticked without a time-stamp edge");

  chk_bus_ref: assert property (
    @(posedge clk) disable iff (!resetn)
    (en2 && bus_ref && bus_edge && !halted && !ev_q.thermal_stop_clock && !wr_stb)
      |=> fix2 == $past(fix2) + 64'h1)
    else $error("bus clock tick not counted in legacy mode");

  chk_read_quiet: assert property (
    @(posedge clk) disable iff (!resetn)
    (setup && !pwrite && hit) |=> (pready && prdata == $past(rd_word)) ##1 !pready)
    else $error("read answer wrong or not one cycle");

endmodule

//--- test/tb_pfc_top.sv
/*
 * Self-checking testbench of the performance event counters: APB tasks,
 * core event stimulus, time-stamp and bus-clock toggles.
 * Assumes pfc_top answers every access in its first access cycle and
 * registers core events once before they reach the counters.
 */
`timescale 1ns/1ns
`include "pfc_consts.svh"

module tb_pfc_top;
  logic clk;
  logic resetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  pfc_pkg::pfc_core_ev_t core_ev;
  pfc_pkg::pfc_core_ev_t idle_ev;
  pfc_pkg::pfc_core_ev_t run_ev;
  logic tsc_tick_toggle;
  logic bus_clk_toggle;
  int mismatches;
  int samples_checked;
  logic [31:0] rd;
  logic err;

  pfc_top pfc_top_inst (
    .clk(clk),
    .resetn(resetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .core_ev(core_ev),
    .tsc_tick_toggle(tsc_tick_toggle),
    .bus_clk_toggle(bus_clk_toggle)
  );

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // request held until pready is seen at a rising edge; hangs end by watchdog
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    apb(1'b1, {idx, 2'b00}, d);
  endtask

  task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, {idx, 2'b00}, 32'h0000_0000);
    check({err, rd}, {1'b0, exp});
  endtask

  // events held n cycles, then idle long enough for the count to land
  task automatic drive(input pfc_pkg::pfc_core_ev_t ev, input int n);
    repeat (n) begin
      @(posedge clk);
      core_ev <= ev;
    end
    @(posedge clk);
    core_ev <= idle_ev;
    repeat (4) @(posedge clk);
  endtask

  // toggles spaced four clocks apart, well below the clk/2 limit
  task automatic tick(input logic legacy, input int n);
    repeat (n) begin
      repeat (4) @(posedge clk);
      if (legacy) begin
        bus_clk_toggle <= ~bus_clk_toggle;
      end else begin
        tsc_tick_toggle <= ~tsc_tick_toggle;
      end
    end
    repeat (8) @(posedge clk);
  endtask

  task automatic set_core(input pfc_pkg::pfc_core_ev_t ev);
    @(posedge clk);
    core_ev <= ev;
  endtask

  // ****************************************************************
  // clock, reset, watchdog
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude();
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    pfc_pkg::pfc_core_ev_t tgt;
    pfc_pkg::pfc_core_ev_t oth;
    idle_ev = '0;
    idle_ev.halt_instruction = 1'b1;
    run_ev = '0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    core_ev = idle_ev;
    tsc_tick_toggle = 1'b0;
    bus_clk_toggle = 1'b0;
    mismatches = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;

    rdchk(`PFC_IDX_FIX_CTRL, 32'h0000_0000);
    rdchk(`PFC_IDX_EVSEL0, 32'h0000_0000);
    rdchk(`PFC_IDX_FIX0_LO, 32'h0000_0000);
    rdchk(`PFC_IDX_FIX2_HI, 32'h0000_0000);
    rdchk(`PFC_IDX_STATUS, 32'h0000_0002);
    wr(`PFC_IDX_STATUS, 32'hFFFF_FFFF);
    rdchk(`PFC_IDX_STATUS, 32'h0000_0002);
    apb(1'b0, 12'hFFC, 32'h0000_0000);
    check({err, rd}, {1'b1, 32'h0000_0000});
    apb(1'b0, {`PFC_IDX_FIX0_LO, 2'b01}, 32'h0000_0000);
    check({err, rd}, {1'b1, 32'h0000_0000});
    $display("test reset and decode done");

    // retirement ignores the other events; halted core keeps counter 1 still
    wr(`PFC_IDX_FIX_CTRL, 32'h0000_0111);
    tgt = idle_ev;
    tgt.instr_retired = 1'b1;
    tgt.branch_retired = 1'b1;
    tgt.llc_miss = 1'b1;
    drive(tgt, 5);
    rdchk(`PFC_IDX_FIX0_LO, 32'h0000_0005);
    rdchk(`PFC_IDX_FIX1_LO, 32'h0000_0000);
    rdchk(`PFC_IDX_FIX2_LO, 32'h0000_0000);
    wr(`PFC_IDX_FIX0_LO, 32'hFFFF_FFFE);
    drive(tgt, 3);
    rdchk(`PFC_IDX_FIX0_LO, 32'h0000_0001);
    rdchk(`PFC_IDX_FIX0_LO, 32'h0000_0001);
    rdchk(`PFC_IDX_FIX0_HI, 32'h0000_0001);
    $display("test retired instructions done");

    drive(run_ev, 7);
    rdchk(`PFC_IDX_FIX1_LO, 32'h0000_0007);
    tgt = run_ev;
    tgt.monitor_wait_instruction = 1'b1;
    drive(tgt, 6);
    rdchk(`PFC_IDX_FIX1_LO, 32'h0000_0007);
    tgt = idle_ev;
    tgt.sibling_unhalted = 1'b1;
    drive(tgt, 4);
    rdchk(`PFC_IDX_FIX1_LO, 32'h0000_0007);
    wr(`PFC_IDX_FIX_CTRL, 32'h0000_0151);
    drive(tgt, 4);
    rdchk(`PFC_IDX_FIX1_LO, 32'h0000_000B);
    $display("test core cycles done");

    set_core(run_ev);
    tick(1'b0, 6);
    rdchk(`PFC_IDX_FIX2_LO, 32'h0000_0006);
    tgt = run_ev;
    tgt.thermal_stop_clock = 1'b1;
    set_core(tgt);
    tick(1'b0, 3);
    rdchk(`PFC_IDX_FIX2_LO, 32'h0000_0006);
    rdchk(`PFC_IDX_STATUS, 32'h0000_0004);
    set_core(idle_ev);
    tick(1'b0, 3);
    rdchk(`PFC_IDX_FIX2_LO, 32'h0000_0006);
    wr(`PFC_IDX_FIX_CTRL, 32'h0000_1151);
    set_core(run_ev);
    tick(1'b0, 3);
    rdchk(`PFC_IDX_FIX2_LO, 32'h0000_0006);
    tick(1'b1, 5);
    rdchk(`PFC_IDX_FIX2_LO, 32'h0000_000B);
    // back to time-stamp reference, else 3C/01 below sees no ticks
    wr(`PFC_IDX_FIX_CTRL, 32'h0000_0151);
    set_core(idle_ev);
    $display("test reference cycles done");

    // each selectable event, then every other event as a distractor
    for (int i = 0; i < 8; i++) begin
      logic [7:0] code;
      logic [7:0] um;
      case (i)
        0: begin code = 8'h3C; um = 8'h00; end
        1: begin code = 8'h3C; um = 8'h01; end
        2: begin code = 8'hC0; um = 8'h00; end
        3: begin code = 8'h2E; um = 8'h4F; end
        4: begin code = 8'h2E; um = 8'h41; end
        5: begin code = 8'hC4; um = 8'h00; end
        6: begin code = 8'hC5; um = 8'h00; end
        default: begin code = 8'h3C; um = 8'h02; end
      endcase
      wr(`PFC_IDX_EVSEL0, 32'h0040_0000 | {16'h0000, um, code});
      wr(`PFC_IDX_GP0_LO, 32'h0000_0000);
      wr(`PFC_IDX_GP0_HI, 32'h0000_0000);
      tgt = idle_ev;
      oth = idle_ev;
      oth.instr_retired = 1'b1;
      oth.branch_retired = 1'b1;
      oth.branch_mispred = 1'b1;
      oth.last_level_cache_reference_event = 1'b1;
      oth.llc_miss = 1'b1;
      case (i)
        0: tgt.halt_instruction = 1'b0;
        2: begin tgt.instr_retired = 1'b1; oth.instr_retired = 1'b0; end
        3: begin tgt.last_level_cache_reference_event = 1'b1; oth.last_level_cache_reference_event = 1'b0; end
        4: begin tgt.llc_miss = 1'b1; oth.llc_miss = 1'b0; end
        5: begin tgt.branch_retired = 1'b1; oth.branch_retired = 1'b0; end
        6: begin tgt.branch_mispred = 1'b1; oth.branch_mispred = 1'b0; end
        7: begin tgt = oth; tgt.halt_instruction = 1'b0; end
        default: tgt = idle_ev;
      endcase
      if (i == 1) begin
        set_core(run_ev);
        tick(1'b0, 6);
        set_core(idle_ev);
      end else begin
        drive(tgt, 6);
      end
      drive(oth, 3);
      rdchk(`PFC_IDX_GP0_LO, (i == 7) ? 32'h0000_0000 : 32'h0000_0006);
    end
    $display("test event select done");
    conclude();
  end
endmodule
